// ===== shared/clksel_pkg.sv
// Constants, register map and encodings of the slow clock source selector
package clksel_pkg;

  // Bus clock and timing
  localparam int unsigned CLK_PERIOD_NS    = 25;
  localparam int unsigned OSC_TIMEOUT_NS   = 100000;
  localparam int unsigned OSC_TIMEOUT_CYC  = (OSC_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned OSC_START_EDGES  = 4;

  // Register byte offsets
  localparam logic [11:0] ADDR_SRC_STATUS  = 12'h000;
  localparam logic [11:0] ADDR_INT_STATUS  = 12'h004;
  localparam logic [11:0] ADDR_INT_MASK    = 12'h008;
  localparam logic [11:0] ADDR_CONTROL     = 12'h00c;
  localparam logic [11:0] ADDR_SUPPLY      = 12'h010;

  // Field positions
  localparam int unsigned BIT_SRC_XTAL     = 0;
  localparam int unsigned BIT_XTAL_RUN     = 1;
  localparam int unsigned BIT_RC_RUN       = 2;
  localparam int unsigned BIT_SWITCHING    = 3;
  localparam int unsigned BIT_CLK_CHANGE   = 0;
  localparam int unsigned BIT_KEEPALIVE    = 0;
  localparam int unsigned LSB_DRIVE_SEL    = 1;
  localparam int unsigned BIT_SUPPLY_EN    = 0;
  localparam int unsigned BIT_SUPPLY_1V3   = 1;
  localparam int unsigned LSB_POWER_UP_SELECT_PINS         = 4;

  // Reset values
  localparam logic [1:0]  DRIVE_SEL_RST    = 2'h1;
  localparam logic        MASK_RST         = 1'b1;
  localparam logic        KEEPALIVE_RST    = 1'b0;
  localparam logic [1:0]  POWER_UP_SELECT_PINS_SETTLE      = 2'h3;

  // Power-up select codes that raise the supply to the high level
  localparam logic [3:0]  POWER_UP_SELECT_PINS_HI_A        = 4'h6;
  localparam logic [3:0]  POWER_UP_SELECT_PINS_HI_B        = 4'h7;
  localparam logic [3:0]  POWER_UP_SELECT_PINS_HI_C        = 4'h8;
  localparam logic [3:0]  POWER_UP_SELECT_PINS_HI_D        = 4'h9;

  // Operating modes reported by the power state logic
  typedef enum logic [2:0] {
    MODE_ON         = 3'b000,
    MODE_STANDBY    = 3'b001,
    MODE_LP_STANDBY = 3'b010,
    MODE_OFF        = 3'b011,
    MODE_COIN_CELL  = 3'b100
  } power_mode_e;

  // Source selector states
  typedef enum logic [1:0] {
    SRC_RC     = 2'b00,
    SRC_XTAL   = 2'b01,
    SRC_SWITCH = 2'b10
  } src_state_e;

endpackage : clksel_pkg

// ===== shared/osc_mon_if.sv
// Oscillator monitor results passed to the selector
`timescale 1ns/100ps
interface osc_mon_if;
  logic level;
  logic rise;
  logic running;

  modport mon  (output level, output rise, output running);
  modport user (input  level, input  rise, input  running);
endinterface : osc_mon_if

// ===== hdl/osc_activity_monitor.sv
// Synchronises one oscillator pin and decides whether it is running
`timescale 1ns/100ps
module osc_activity_monitor #(
  parameter int unsigned TIMEOUT_CYC = clksel_pkg::OSC_TIMEOUT_CYC,
  parameter int unsigned START_EDGES = clksel_pkg::OSC_START_EDGES
) (
  input  wire logic  pclk,
  input  wire logic  presetn,
  input  wire logic  osc_pin,
  osc_mon_if.mon     mon
);

  localparam int unsigned CW = $clog2(TIMEOUT_CYC + 1);
  localparam int unsigned EW = $clog2(START_EDGES + 1);
  localparam logic [CW-1:0] TMO_MAX  = CW'(TIMEOUT_CYC);
  localparam logic [EW-1:0] EDGE_MAX = EW'(START_EDGES);

  logic          meta_r;
  logic          sync_r;
  logic          prev_r;
  logic [CW-1:0] idle_r;
  logic [CW-1:0] idle_nxt;
  logic [EW-1:0] edges_r;
  logic [EW-1:0] edges_nxt;
  logic          run_r;
  logic          run_nxt;
  logic          rise;

  // Two-stage synchroniser and edge history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      meta_r <= osc_pin;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign rise = sync_r & ~prev_r;

  // Running after enough edges, stopped after a silent timeout
  always_comb begin
    idle_nxt  = idle_r;
    edges_nxt = edges_r;
    run_nxt   = run_r;
    if (rise) begin
      idle_nxt = '0;
      if (edges_r != EDGE_MAX) begin
        edges_nxt = edges_r + EW'(1);
      end
      if (edges_r >= EDGE_MAX - EW'(1)) begin
        run_nxt = 1'b1;
      end
    end else if (idle_r == TMO_MAX) begin
      edges_nxt = '0;
      run_nxt   = 1'b0;
    end else begin
      idle_nxt = idle_r + CW'(1);
    end
  end

  // Monitor state registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_r  <= '0;
      edges_r <= '0;
      run_r   <= 1'b0;
    end else begin
      idle_r  <= idle_nxt;
      edges_r <= edges_nxt;
      run_r   <= run_nxt;
    end
  end

  assign mon.level   = sync_r;
  assign mon.rise    = rise;
  assign mon.running = run_r;

endmodule : osc_activity_monitor

// ===== hdl/slow_clock_source_select.sv
// Slow time base selector with glitch-free switch, interrupt and supply control
//
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/100ps
// Function
// - Use internal RC time base whenever the crystal is not running.
// - RC runs only with valid main supply; never selected while crystal active.
// - Control logic runs from selected time base, crystal whenever it runs.
// - Output held at a stable phase during source switching, no runt pulse.
// - Crystal stopping during operation reverts selection to the RC oscillator.
// - Source status bit reads 0 for RC, 1 for crystal.
// - Clock-change flag sets on every source change, either direction.
// - Clock-change flag raises interrupt only when its mask bit is clear.
// - Keepalive 1 keeps processor reference clock driver on in all states.
// - Keepalive 0 turns processor reference clock driver off in Off.
// - Select codes 0110-1001 give 1.3 V in On modes, 1.2 V otherwise.
// - Any other select code gives 1.2 V secure supply in every mode.
// - Secure supply enabled from power-on reset, never disabled.
// - Two-bit output drive select sets clock edge strength, resets to 01.
// - Clock-change flag latches; writing 1 clears it and may drop interrupt.
// - Masks set at power-up; unmasking a set flag raises interrupt at once.
module slow_clock_source_select (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        xtal_clk_pin,
  input  wire logic        rc_clk_pin,
  input  wire logic        main_supply_valid_pin,
  input  wire logic [3:0]  power_up_select_pins,
  input  wire logic [2:0]  power_mode,
  output logic             system_slow_clock_out,
  output logic             processor_ref_clock_out,
  output logic             processor_ref_clock_oe,
  output logic             rc_osc_enable,
  output logic             time_base_tick,
  output logic [1:0]       output_drive_select,
  output logic             secure_rtc_supply_enable,
  output logic             secure_rtc_supply_1v3,
  output logic             irq
);

  osc_mon_if xtal_mon ();
  osc_mon_if rc_mon ();

  // Crystal and RC pin monitors
  // synchronised running flag
  osc_activity_monitor #(
    .TIMEOUT_CYC (clksel_pkg::OSC_TIMEOUT_CYC),
    .START_EDGES (clksel_pkg::OSC_START_EDGES)
  ) u_xtal_mon (
    .pclk    (pclk),
    .presetn (presetn),
    .osc_pin (xtal_clk_pin),
    .mon     (xtal_mon.mon)
  );

  osc_activity_monitor #(
    .TIMEOUT_CYC (clksel_pkg::OSC_TIMEOUT_CYC),
    .START_EDGES (clksel_pkg::OSC_START_EDGES)
  ) u_rc_mon (
    .pclk    (pclk),
    .presetn (presetn),
    .osc_pin (rc_clk_pin),
    .mon     (rc_mon.mon)
  );

  // ---------------------------------------------------------------
  // Pin synchronisers and strap capture
  logic       sup_meta_r;
  logic       sup_sync_r;
  logic [3:0] power_up_select_pins_meta_r;
  logic [3:0] power_up_select_pins_sync_r;

  // Two flops on supply valid and power-up select pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sup_meta_r  <= 1'b0;
      sup_sync_r  <= 1'b0;
      power_up_select_pins_meta_r <= 4'h0;
      power_up_select_pins_sync_r <= 4'h0;
    end else begin
      sup_meta_r  <= main_supply_valid_pin;
      sup_sync_r  <= sup_meta_r;
      power_up_select_pins_meta_r <= power_up_select_pins;
      power_up_select_pins_sync_r <= power_up_select_pins_meta_r;
    end
  end

  logic [1:0] settle_r;
  logic [1:0] settle_nxt;
  logic [3:0] power_up_select_pins_r;
  logic [3:0] power_up_select_pins_nxt;

  // Latch straps once the synchroniser has settled after reset
  always_comb begin
    settle_nxt = settle_r;
    power_up_select_pins_nxt   = power_up_select_pins_r;
    if (settle_r != clksel_pkg::POWER_UP_SELECT_PINS_SETTLE) begin
      settle_nxt = settle_r + 2'h1;
    end
    if (settle_r == clksel_pkg::POWER_UP_SELECT_PINS_SETTLE - 2'h1) begin
      power_up_select_pins_nxt = power_up_select_pins_sync_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_r <= 2'h0;
      power_up_select_pins_r   <= 4'h0;
    end else begin
      settle_r <= settle_nxt;
      power_up_select_pins_r   <= power_up_select_pins_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Source selection state machine
  clksel_pkg::src_state_e state_r;
  clksel_pkg::src_state_e state_nxt;
  logic tgt_xtal_r;
  logic tgt_xtal_nxt;
  logic out_r;
  logic out_nxt;
  logic changed;

  // Follow the chosen source; hold output steady while switching
  always_comb begin
    state_nxt    = state_r;
    tgt_xtal_nxt = tgt_xtal_r;
    out_nxt      = out_r;
    changed      = 1'b0;
    unique case (state_r)
      clksel_pkg::SRC_RC: begin
        out_nxt = rc_mon.level;
        if (xtal_mon.running) begin
          state_nxt    = clksel_pkg::SRC_SWITCH;
          tgt_xtal_nxt = 1'b1;
          out_nxt      = out_r;
        end
      end
      clksel_pkg::SRC_XTAL: begin
        out_nxt = xtal_mon.level;
        if (!xtal_mon.running) begin
          state_nxt    = clksel_pkg::SRC_SWITCH;
          tgt_xtal_nxt = 1'b0;
          out_nxt      = out_r;
        end
      end
      clksel_pkg::SRC_SWITCH: begin
        // finish RC high phase, then hold low until crystal low
        if (tgt_xtal_r) begin
          out_nxt = out_r & rc_mon.level & rc_mon.running;
        end
        if (tgt_xtal_r && !xtal_mon.running) begin
          state_nxt = clksel_pkg::SRC_RC;
        end else if (tgt_xtal_r && !xtal_mon.level && !out_r) begin
          state_nxt = clksel_pkg::SRC_XTAL;
          changed   = 1'b1;
        end else if (!tgt_xtal_r && xtal_mon.running) begin
          state_nxt = clksel_pkg::SRC_XTAL;
        end else if (!tgt_xtal_r && (rc_mon.level == out_r)) begin
          state_nxt = clksel_pkg::SRC_RC;
          changed   = 1'b1;
        end
      end
      default: begin
        state_nxt = clksel_pkg::SRC_RC;
      end
    endcase
  end

  logic tick_nxt;
  logic tick_r;

  // One-cycle enable on each rising edge of the selected clock
  // enable for slow control logic
  assign tick_nxt = out_nxt & ~out_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r    <= clksel_pkg::SRC_RC;
      tgt_xtal_r <= 1'b0;
      out_r      <= 1'b0;
      tick_r     <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      tgt_xtal_r <= tgt_xtal_nxt;
      out_r      <= out_nxt;
      tick_r     <= tick_nxt;
    end
  end

  logic src_xtal;
  // status 1 while crystal selected and while switching from crystal back to RC
  assign src_xtal = (state_r == clksel_pkg::SRC_XTAL) ||
                    ((state_r == clksel_pkg::SRC_SWITCH) && !tgt_xtal_r);

  // ---------------------------------------------------------------
  // APB register file
  logic        flag_r;
  logic        flag_nxt;
  logic        mask_r;
  logic        mask_nxt;
  logic        keep_r;
  logic        keep_nxt;
  logic [1:0]  drv_r;
  logic [1:0]  drv_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic        wr_acc;
  logic        mapped;
  logic        hi_code;
  logic        sup_1v3;

  assign mapped = (paddr == clksel_pkg::ADDR_SRC_STATUS) || (paddr == clksel_pkg::ADDR_INT_STATUS) ||
                  (paddr == clksel_pkg::ADDR_INT_MASK)   || (paddr == clksel_pkg::ADDR_CONTROL) ||
                  (paddr == clksel_pkg::ADDR_SUPPLY);
  assign wr_acc = psel & penable & pwrite & mapped;

  // Supply level decode from latched straps and current mode
  // high level only in On modes
  assign hi_code = (power_up_select_pins_r == clksel_pkg::POWER_UP_SELECT_PINS_HI_A) || (power_up_select_pins_r == clksel_pkg::POWER_UP_SELECT_PINS_HI_B) ||
                   (power_up_select_pins_r == clksel_pkg::POWER_UP_SELECT_PINS_HI_C) || (power_up_select_pins_r == clksel_pkg::POWER_UP_SELECT_PINS_HI_D);
  assign sup_1v3 = hi_code && ((power_mode == clksel_pkg::MODE_ON) ||
                               (power_mode == clksel_pkg::MODE_STANDBY) ||
                               (power_mode == clksel_pkg::MODE_LP_STANDBY));

  // Register writes, flag set and read data capture in setup phase
  always_comb begin
    flag_nxt  = flag_r;
    mask_nxt  = mask_r;
    keep_nxt  = keep_r;
    drv_nxt   = drv_r;
    rdata_nxt = rdata_r;
    if (wr_acc) begin
      unique case (paddr)
        clksel_pkg::ADDR_INT_STATUS: begin
          if (pwdata[clksel_pkg::BIT_CLK_CHANGE]) begin
            flag_nxt = 1'b0;
          end
        end
        clksel_pkg::ADDR_INT_MASK: begin
          mask_nxt = pwdata[clksel_pkg::BIT_CLK_CHANGE];
        end
        clksel_pkg::ADDR_CONTROL: begin
          keep_nxt = pwdata[clksel_pkg::BIT_KEEPALIVE];
          drv_nxt  = pwdata[clksel_pkg::LSB_DRIVE_SEL +: 2];
        end
        default: begin
        end
      endcase
    end
    // source change sets flag, set wins
    if (changed) begin
      flag_nxt = 1'b1;
    end
    if (psel && !penable) begin
      rdata_nxt = 32'h0;
      unique case (paddr)
        clksel_pkg::ADDR_SRC_STATUS: begin
          rdata_nxt[clksel_pkg::BIT_SRC_XTAL]  = src_xtal;
          rdata_nxt[clksel_pkg::BIT_XTAL_RUN]  = xtal_mon.running;
          rdata_nxt[clksel_pkg::BIT_RC_RUN]    = rc_mon.running;
          rdata_nxt[clksel_pkg::BIT_SWITCHING] = (state_r == clksel_pkg::SRC_SWITCH);
        end
        clksel_pkg::ADDR_INT_STATUS: begin
          rdata_nxt[clksel_pkg::BIT_CLK_CHANGE] = flag_r;
        end
        clksel_pkg::ADDR_INT_MASK: begin
          rdata_nxt[clksel_pkg::BIT_CLK_CHANGE] = mask_r;
        end
        clksel_pkg::ADDR_CONTROL: begin
          rdata_nxt[clksel_pkg::BIT_KEEPALIVE]      = keep_r;
          rdata_nxt[clksel_pkg::LSB_DRIVE_SEL +: 2] = drv_r;
        end
        clksel_pkg::ADDR_SUPPLY: begin
          rdata_nxt[clksel_pkg::BIT_SUPPLY_EN]   = 1'b1;
          rdata_nxt[clksel_pkg::BIT_SUPPLY_1V3]  = sup_1v3;
          rdata_nxt[clksel_pkg::LSB_POWER_UP_SELECT_PINS +: 4]   = power_up_select_pins_r;
        end
        default: begin
        end
      endcase
    end
  end

  // Register state; masks come up set
  // masked at power-up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_r  <= 1'b0;
      mask_r  <= clksel_pkg::MASK_RST;
      keep_r  <= clksel_pkg::KEEPALIVE_RST;
      drv_r   <= clksel_pkg::DRIVE_SEL_RST;
      rdata_r <= 32'h0;
    end else begin
      flag_r  <= flag_nxt;
      mask_r  <= mask_nxt;
      keep_r  <= keep_nxt;
      drv_r   <= drv_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Zero-wait access phase; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata  = rdata_r;

  // ---------------------------------------------------------------
  // Outputs
  logic ref_oe_r;
  logic ref_oe_nxt;
  logic rc_en_r;
  logic v13_r;
  logic irq_r;
  logic irq_nxt;

  // otherwise off in Off and coin cell
  assign ref_oe_nxt = keep_r || !((power_mode == clksel_pkg::MODE_OFF) ||
                                  (power_mode == clksel_pkg::MODE_COIN_CELL));
  // unmask of a set flag asserts next cycle
  assign irq_nxt = flag_nxt & ~mask_nxt;

  // Registered output drivers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_oe_r <= 1'b0;
      rc_en_r  <= 1'b0;
      v13_r    <= 1'b0;
      irq_r    <= 1'b0;
    end else begin
      ref_oe_r <= ref_oe_nxt;
      // RC enabled only with valid supply
      rc_en_r  <= sup_sync_r;
      v13_r    <= sup_1v3;
      irq_r    <= irq_nxt;
    end
  end

  assign system_slow_clock_out   = out_r;
  assign processor_ref_clock_out = out_r & ref_oe_r;
  assign processor_ref_clock_oe  = ref_oe_r;
  assign rc_osc_enable           = rc_en_r;
  assign time_base_tick          = tick_r;
  assign output_drive_select     = drv_r;
  assign secure_rtc_supply_enable = 1'b1;
  assign secure_rtc_supply_1v3   = v13_r;
  assign irq                     = irq_r;

endmodule : slow_clock_source_select

// ===== verif/proc_side_model.sv
// Processor-side model: secure clock receiver and push-pull power key driver
`timescale 1ns/100ps
module proc_side_model (
  input  wire logic        ref_clk,
  input  wire logic        wake_req,
  output logic             power_key_n,
  output logic [15:0]      ref_rises
);
  initial ref_rises = 16'h0;

  // count reference edges reaching the secure clock
  always @(posedge ref_clk) begin
    ref_rises <= ref_rises + 16'h1;
  end

  // push-pull drive beside the power key: low on wake request, high otherwise
  assign power_key_n = wake_req ? 1'b0 : 1'b1;
endmodule : proc_side_model

// ===== verif/clksel_checker.sv
// Port-level assertions for the slow clock source selector
`timescale 1ns/100ps
module clksel_checker (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic        main_supply_valid_pin,
  input  wire logic [3:0]  power_up_select_pins,
  input  wire logic [2:0]  power_mode,
  input  wire logic        system_slow_clock_out,
  input  wire logic        processor_ref_clock_out,
  input  wire logic        processor_ref_clock_oe,
  input  wire logic        rc_osc_enable,
  input  wire logic        time_base_tick,
  input  wire logic [1:0]  output_drive_select,
  input  wire logic        secure_rtc_supply_enable,
  input  wire logic        secure_rtc_supply_1v3,
  input  wire logic        irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_SUPPLY_ON: assert property (secure_rtc_supply_enable) else $error("secure supply off");
  AST_DRIVE_RST: assert property ($rose(presetn) |-> output_drive_select == 2'h1) else $error("drive reset");
  AST_TICK: assert property ($rose(system_slow_clock_out) |-> time_base_tick) else $error("tick missing");
  AST_NO_RUNT: assert property ($rose(system_slow_clock_out) |=> system_slow_clock_out [*4]) else $error("runt");
  AST_RC_OFF: assert property (!main_supply_valid_pin [*4] |-> !rc_osc_enable) else $error("rc on");
  // high level only in active modes
  AST_HI_MODE: assert property (secure_rtc_supply_1v3 |-> $past(power_mode) < 3'h3) else $error("1v3 mode");
  // high level only for listed codes
  AST_HI_CODE: assert property (secure_rtc_supply_1v3 |-> power_up_select_pins inside {[4'h6:4'h9]})
    else $error("1v3 code");
  AST_REF_GATE: assert property (processor_ref_clock_out |-> processor_ref_clock_oe) else $error("ref gate");
  AST_REF_ON: assert property ((power_mode < 3'h3) [*3] |-> processor_ref_clock_oe) else $error("ref oe");
  AST_MASK: assert property (psel && penable && pwrite && paddr == 12'h008 && pwdata[0] |-> ##2 !irq)
    else $error("mask irq");
  AST_CLEAR: assert property (psel && penable && pwrite && paddr == 12'h004 && pwdata[0] |-> ##2 !irq)
    else $error("clear irq");
endmodule : clksel_checker

bind slow_clock_source_select clksel_checker i_clksel_checker (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .main_supply_valid_pin(main_supply_valid_pin), .power_up_select_pins(power_up_select_pins),
  .power_mode(power_mode), .system_slow_clock_out(system_slow_clock_out),
  .processor_ref_clock_out(processor_ref_clock_out), .processor_ref_clock_oe(processor_ref_clock_oe),
  .rc_osc_enable(rc_osc_enable), .time_base_tick(time_base_tick), .output_drive_select(output_drive_select),
  .secure_rtc_supply_enable(secure_rtc_supply_enable), .secure_rtc_supply_1v3(secure_rtc_supply_1v3), .irq(irq)
);

// ===== verif/tb_slow_clock_source_select.sv
// Register-level testbench of the slow clock source selector
`timescale 1ns/100ps
module tb_slow_clock_source_select;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic        xtal_clk_pin = 1'b0;
  logic        rc_clk_pin = 1'b0;
  logic        main_supply_valid_pin = 1'b1;
  logic [3:0]  power_up_select_pins = 4'h7;
  logic [2:0]  power_mode = 3'h0;
  logic [31:0] prdata, rdat;
  logic        pready, pslverr, rerr, ref_out, ref_oe, rc_en, tick, sup_en, sup_hi, irq, slow_out;
  logic [1:0]  drv;
  logic [15:0] ref_rises, e0;
  logic [3:0]  c;
  logic        xtal_on = 1'b0;
  int          cnt = 0;
  int          err_total = 0;
  int          checks_done = 0;

  slow_clock_source_select i_slow_clock_source_select (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .xtal_clk_pin(xtal_clk_pin),
    .rc_clk_pin(rc_clk_pin), .main_supply_valid_pin(main_supply_valid_pin),
    .power_up_select_pins(power_up_select_pins), .power_mode(power_mode), .system_slow_clock_out(slow_out),
    .processor_ref_clock_out(ref_out), .processor_ref_clock_oe(ref_oe), .rc_osc_enable(rc_en),
    .time_base_tick(tick), .output_drive_select(drv), .secure_rtc_supply_enable(sup_en),
    .secure_rtc_supply_1v3(sup_hi), .irq(irq)
  );

  proc_side_model i_proc_side_model (.ref_clk(ref_out), .wake_req(1'b0), .power_key_n(), .ref_rises(ref_rises));

  always #12.5 pclk = ~pclk;

  // Oscillator stand-ins: crystal on demand, RC while enabled
  always @(posedge pclk) begin
    cnt <= cnt + 1;
    if (xtal_on && cnt % 17 == 0) xtal_clk_pin <= ~xtal_clk_pin;
    if (cnt % 11 == 0) rc_clk_pin <= (rc_en === 1'b1) ? ~rc_clk_pin : 1'b0;
  end

  task automatic tally_and_finish();
    if (err_total == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdat & m, exp);
  endtask : rdc

  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : settle

  // Poll source status until it shows the wanted source
  task automatic wait_src(input logic exp);
    int n;
    n = 0;
    do begin
      apb(1'b0, 12'h000, 32'h0);
      n++;
    end while (rdat[0] !== exp && n < 3000);
  endtask : wait_src

  task automatic do_reset(input logic [3:0] code);
    @(posedge pclk);
    presetn <= 1'b0;
    power_mode <= 3'h0;
    power_up_select_pins <= code;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    settle(6);
  endtask : do_reset

  // Watchdog
  initial begin
    repeat (60000) @(posedge pclk);
    err_total++;
    tally_and_finish();
  end

  initial begin
    do_reset(4'h7);
    rdc(12'h010, 32'hf3, 32'h73);
    rdc(12'h00c, 32'h7, 32'h2);
    rdc(12'h008, 32'h1, 32'h1);
    apb(1'b1, 12'h010, 32'h0);
    rdc(12'h010, 32'hf3, 32'h73);
    apb(1'b0, 12'h020, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    settle(150);
    rdc(12'h000, 32'h5, 32'h4);
    // Crystal starts: switch, flag, masked line
    xtal_on = 1'b1;
    wait_src(1'b1);
    rdc(12'h000, 32'h1, 32'h1);
    rdc(12'h004, 32'h1, 32'h1);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, 12'h008, 32'h0);
    settle(2);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, 12'h004, 32'h1);
    settle(2);
    chk({31'h0, irq}, 32'h0);
    rdc(12'h004, 32'h1, 32'h0);
    // Crystal stops: fall back to RC
    xtal_on = 1'b0;
    wait_src(1'b0);
    rdc(12'h000, 32'h5, 32'h4);
    settle(2);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, 12'h008, 32'h1);
    settle(2);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, 12'h004, 32'h1);
    // Keepalive against every operating mode
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, 12'h00c, {30'h1, k[0]});
      for (int m = 0; m < 5; m++) begin
        @(posedge pclk);
        power_mode <= m[2:0];
        settle(4);
        e0 = ref_rises;
        chk({31'h0, ref_oe}, {31'h0, k[0] | (m < 3)});
        chk({31'h0, sup_hi}, {31'h0, m < 3});
        settle(100);
        chk({31'h0, ref_rises != e0}, {31'h0, k[0] | (m < 3)});
      end
    end
    // Every drive strength code
    for (int d = 0; d < 4; d++) begin
      apb(1'b1, 12'h00c, {29'h0, d[1:0], 1'b0});
      settle(1);
      chk({30'h0, drv}, d);
    end
    // Supply loss stops the RC oscillator
    @(posedge pclk);
    main_supply_valid_pin <= 1'b0;
    settle(6);
    chk({31'h0, rc_en}, 32'h0);
    @(posedge pclk);
    main_supply_valid_pin <= 1'b1;
    // Strap codes at both edges of the high range
    for (int i = 0; i < 4; i++) begin
      c = (i == 0) ? 4'h5 : (i == 1) ? 4'h6 : (i == 2) ? 4'h9 : 4'ha;
      do_reset(c);
      rdc(12'h010, 32'hf3, {24'h0, c, 2'b0, (c >= 4'h6 && c <= 4'h9), 1'b1});
    end
    tally_and_finish();
  end
endmodule : tb_slow_clock_source_select
